// ---- logic/mcast_router_pkg.sv ----
package mcast_router_pkg;

    // Switch shape
    localparam int NUM_FUNC = 4;
    localparam int FUNC_W = 2;
    localparam int ADDR_W = 8;
    localparam int GROUP_W = 6;

    // Global register offsets
    localparam logic [7:0] OFF_CAPABILITY = 8'h00;
    localparam logic [7:0] OFF_CONTROL = 8'h04;
    localparam logic [7:0] OFF_BASE_LOW = 8'h08;
    localparam logic [7:0] OFF_BASE_HIGH = 8'h0C;
    localparam logic [7:0] OFF_HDR_LOG_LOW = 8'h10;
    localparam logic [7:0] OFF_HDR_LOG_HIGH = 8'h14;
    localparam logic [7:0] OFF_HDR_LOG_INFO = 8'h18;

    // Per-function register block: base bit, index field, local offsets
    localparam int FUNC_SEL_BIT = 7;
    localparam int FUNC_IDX_LSB = 5;
    localparam logic [4:0] OFF_BLK_ALL_LOW = 5'h00;
    localparam logic [4:0] OFF_BLK_ALL_HIGH = 5'h04;
    localparam logic [4:0] OFF_BLK_UT_LOW = 5'h08;
    localparam logic [4:0] OFF_BLK_UT_HIGH = 5'h0C;
    localparam logic [4:0] OFF_RCV_LOW = 5'h10;
    localparam logic [4:0] OFF_RCV_HIGH = 5'h14;
    localparam logic [4:0] OFF_FUNC_CTRL = 5'h18;
    localparam logic [4:0] OFF_FUNC_STATUS = 5'h1C;

    // Field positions
    localparam int CTRL_ENABLE_BIT = 15;
    localparam int FCTRL_FUNCTION_MCAST_ENABLE_BIT = 0;
    localparam int FCTRL_UPSTREAM_BIT = 1;
    localparam int STS_PRIMARY_BIT = 0;
    localparam int STS_SECONDARY_BIT = 1;
    localparam int BASE_LOW_LSB = 12;

    // Reset values
    localparam logic [5:0] MAX_GROUP_RESET = 6'h1F;
    localparam logic [5:0] GROUP_COUNT_RESET = 6'h00;
    localparam logic [5:0] INDEX_POS_RESET = 6'h00;

    // Request kinds on the ingress stream
    localparam logic [1:0] KIND_MEM_WRITE = 2'h0;
    localparam logic [1:0] KIND_ADDR_MSG = 2'h1;
    localparam logic [1:0] KIND_OTHER = 2'h2;

    // Address type meaning untranslated
    localparam logic [1:0] AT_UNTRANSLATED = 2'h0;

endpackage

// ---- logic/multicast_tlp_router.sv ----
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
//
// Contract
// - Only memory writes, address messages are candidates
// - Global enable clear means all unicast
// - Group windows contiguous, only enabled count
// - Window size two to index position
// - Base address held as 64 bits
// - Mask low and group bits, compare base
// - Group ID width ceil log2 count plus one
// - Group ID above count means not multicast
// - Only source validation check on multicast
// - Per-group block-all bit blocks TLP
// - Block-untranslated bit with untranslated AT blocks
// - Blocked TLP dropped, credits returned
// - Blocked TLP reports error, logs header
// - Blocked sets target abort by port role
// - Same forwarding everywhere, offered to all
// - Ingress function never accepts own TLP
// - Accept needs enable and receive bit
// - Accepting function sends on own link
// - Unaccepted multicast discarded without error
// - Posted ordering kept, common error checks
// - Max group count defaults 31, writable
//
module multicast_tlp_router (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [31:0] reg_rdata_out,
    // Ingress TLP stream
    input wire logic tlp_valid_in,
    input wire logic [1:0] tlp_ingress_in,
    input wire logic [1:0] tlp_kind_in,
    input wire logic [63:0] tlp_addr_in,
    input wire logic [1:0] tlp_at_in,
    input wire logic tlp_acs_fail_in,
    input wire logic tlp_error_in,
    // Routing decision
    output logic result_valid_out,
    output logic route_unicast_out,
    output logic is_mcast_out,
    output logic [5:0] group_id_out,
    output logic [3:0] egress_vector_out,
    output logic quiet_discard_out,
    output logic acs_violation_out,
    output logic common_error_out,
    // Blocked handling
    output logic blocked_out,
    output logic credit_return_out,
    output logic aer_mc_blocked_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Helper functions

    // Mask of n low ones
    function automatic logic [63:0] low_mask(input logic [6:0] n);
        low_mask = (n >= 7'h40) ? 64'hFFFFFFFFFFFFFFFF : ((64'h1 << n) - 64'h1);
    endfunction

    // Bits needed to number count plus one groups
    function automatic logic [6:0] group_bits(input logic [5:0] count);
        logic [6:0] bits;
        bits = 7'h00;
        for (int i = 0; i < 7; i++) begin
            if ((8'h01 << i) < ({2'h0, count} + 8'h01)) begin
                bits = 7'(i + 1);
            end
        end
        group_bits = bits;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Configuration state

    logic [5:0] max_group_count; // Advertised group limit
    logic mcast_global_enable; // Switch-wide enable
    logic [5:0] enabled_group_count; // Groups enabled, minus one
    logic [5:0] group_index_position; // Window size exponent
    logic [31:mcast_router_pkg::BASE_LOW_LSB] mcast_base_low; // Base address low part
    logic [31:0] mcast_base_high; // Base address high part
    logic [63:0] group_block_all_vector [mcast_router_pkg::NUM_FUNC]; // Per ingress
    logic [63:0] group_block_untranslated_vector [mcast_router_pkg::NUM_FUNC]; // Per ingress
    logic [63:0] group_receive_vector [mcast_router_pkg::NUM_FUNC]; // Per egress
    logic [mcast_router_pkg::NUM_FUNC-1:0] function_mcast_enable; // Per function
    logic [mcast_router_pkg::NUM_FUNC-1:0] function_upstream; // Port role
    logic [mcast_router_pkg::NUM_FUNC-1:0] primary_abort; // Primary status flag
    logic [mcast_router_pkg::NUM_FUNC-1:0] secondary_abort; // Secondary status flag
    logic [63:0] hdr_log_addr; // Logged address
    logic [7:0] hdr_log_info; // Logged kind, AT, ingress

    ////////////////////////////////////////////////////////////////////////////
    // Register decode

    logic func_sel; // Per-function block hit
    logic [1:0] func_idx; // Addressed function
    logic [4:0] func_off; // Offset inside block

    assign func_sel = reg_addr_in[mcast_router_pkg::FUNC_SEL_BIT];
    assign func_idx = reg_addr_in[mcast_router_pkg::FUNC_IDX_LSB +: 2];
    assign func_off = reg_addr_in[4:0];

    ////////////////////////////////////////////////////////////////////////////
    // Decision logic

    logic candidate; // Eligible request kind
    logic [63:0] base_addr; // Full base address
    logic [6:0] gid_width; // Group ID field width
    logic [63:0] idx_mask; // Bits below index position
    logic [63:0] gid_mask_low; // Group field, unshifted
    logic [63:0] gid_mask; // Group field in place
    logic [63:0] gid_shifted; // Address shifted down
    logic base_hit; // Masked address equals base
    logic [5:0] gid; // Extracted group ID
    logic mc_hit; // Multicast determination
    logic blk; // Blocked multicast
    logic [mcast_router_pkg::NUM_FUNC-1:0] accept; // Accepting functions

    // Classify the current request
    always_comb begin
        candidate = (tlp_kind_in == mcast_router_pkg::KIND_MEM_WRITE) ||
                    (tlp_kind_in == mcast_router_pkg::KIND_ADDR_MSG);
        base_addr = {mcast_base_high, mcast_base_low, 12'h000};
        gid_width = group_bits(enabled_group_count);
        idx_mask = low_mask({1'b0, group_index_position});
        gid_mask_low = low_mask(gid_width);
        gid_mask = gid_mask_low << group_index_position;
        base_hit = ((tlp_addr_in & ~(idx_mask | gid_mask)) == base_addr);
        gid_shifted = (tlp_addr_in >> group_index_position) & gid_mask_low;
        gid = gid_shifted[5:0];
        mc_hit = mcast_global_enable && candidate && base_hit &&
                 (gid <= enabled_group_count);
        blk = group_block_all_vector[tlp_ingress_in][gid] ||
              (group_block_untranslated_vector[tlp_ingress_in][gid] &&
               (tlp_at_in == mcast_router_pkg::AT_UNTRANSLATED));
        for (int f = 0; f < mcast_router_pkg::NUM_FUNC; f++) begin
            // Offered to every function but the ingress one
            accept[f] = (2'(f) != tlp_ingress_in) &&
                        function_mcast_enable[f] && group_receive_vector[f][gid];
        end
    end

    logic mc_clean; // Multicast with no error at all
    logic mc_blocked; // Multicast dropped by block bits

    // Source validation first, then common errors, then block bits
    assign mc_clean = mc_hit && !tlp_acs_fail_in && !tlp_error_in && !blk;
    assign mc_blocked = tlp_valid_in && mc_hit && !tlp_acs_fail_in && !tlp_error_in && blk;

    ////////////////////////////////////////////////////////////////////////////
    // Routing outputs, one stage in arrival order

    // Result stage keeps posted order
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            result_valid_out <= 1'b0;
            route_unicast_out <= 1'b0;
            is_mcast_out <= 1'b0;
            group_id_out <= 6'h00;
            egress_vector_out <= 4'h0;
            quiet_discard_out <= 1'b0;
            acs_violation_out <= 1'b0;
            common_error_out <= 1'b0;
        end else begin
            result_valid_out <= tlp_valid_in;
            route_unicast_out <= tlp_valid_in && !mc_hit;
            is_mcast_out <= tlp_valid_in && mc_hit;
            group_id_out <= (tlp_valid_in && mc_hit) ? gid : 6'h00;
            // Accepting functions transmit on their own links
            egress_vector_out <= (tlp_valid_in && mc_clean) ? accept : 4'h0;
            // Nobody accepted: dropped with no report
            quiet_discard_out <= tlp_valid_in && mc_clean && (accept == 4'h0);
            acs_violation_out <= tlp_valid_in && mc_hit && tlp_acs_fail_in;
            // Malformed, poison, ECRC go the usual error path
            common_error_out <= tlp_valid_in && mc_hit && !tlp_acs_fail_in && tlp_error_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Blocked handling

    // Drop, return credits, report to AER
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            blocked_out <= 1'b0;
            credit_return_out <= 1'b0;
            aer_mc_blocked_out <= 1'b0;
        end else begin
            blocked_out <= mc_blocked;
            credit_return_out <= mc_blocked;
            aer_mc_blocked_out <= mc_blocked;
        end
    end

    // Header log of the last blocked TLP
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            hdr_log_addr <= 64'h0;
            hdr_log_info <= 8'h00;
        end else if (mc_blocked) begin
            hdr_log_addr <= tlp_addr_in;
            hdr_log_info <= {2'h0, tlp_kind_in, tlp_at_in, tlp_ingress_in};
        end
    end

    // Target abort flags, set wins over a clear
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            primary_abort <= '0;
            secondary_abort <= '0;
        end else begin
            for (int f = 0; f < mcast_router_pkg::NUM_FUNC; f++) begin
                logic hit_f;
                logic clr_f;
                hit_f = mc_blocked && (tlp_ingress_in == 2'(f));
                clr_f = reg_write_in && func_sel && (func_idx == 2'(f)) &&
                        (func_off == mcast_router_pkg::OFF_FUNC_STATUS);
                if (hit_f && function_upstream[f]) begin
                    // Upstream port: primary status
                    primary_abort[f] <= 1'b1;
                end else if (clr_f && reg_wdata_in[mcast_router_pkg::STS_PRIMARY_BIT]) begin
                    primary_abort[f] <= 1'b0;
                end
                if (hit_f && !function_upstream[f]) begin
                    // Downstream port: secondary status
                    secondary_abort[f] <= 1'b1;
                end else if (clr_f && reg_wdata_in[mcast_router_pkg::STS_SECONDARY_BIT]) begin
                    secondary_abort[f] <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Global register writes

    // Capability, control and base address
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            max_group_count <= mcast_router_pkg::MAX_GROUP_RESET;
            mcast_global_enable <= 1'b0;
            enabled_group_count <= mcast_router_pkg::GROUP_COUNT_RESET;
            group_index_position <= mcast_router_pkg::INDEX_POS_RESET;
            mcast_base_low <= '0;
            mcast_base_high <= 32'h0;
        end else if (reg_write_in && !func_sel) begin
            case (reg_addr_in)
                mcast_router_pkg::OFF_CAPABILITY: begin
                    // Reprogrammable during initial setup
                    max_group_count <= reg_wdata_in[5:0];
                end
                mcast_router_pkg::OFF_CONTROL: begin
                    mcast_global_enable <= reg_wdata_in[mcast_router_pkg::CTRL_ENABLE_BIT];
                    enabled_group_count <= reg_wdata_in[5:0];
                end
                mcast_router_pkg::OFF_BASE_LOW: begin
                    group_index_position <= reg_wdata_in[5:0];
                    mcast_base_low <= reg_wdata_in[31:mcast_router_pkg::BASE_LOW_LSB];
                end
                mcast_router_pkg::OFF_BASE_HIGH: begin
                    mcast_base_high <= reg_wdata_in;
                end
                default: begin
                    // Read-only or unmapped: ignored
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-function register writes

    // Block, receive and control per function
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            for (int f = 0; f < mcast_router_pkg::NUM_FUNC; f++) begin
                group_block_all_vector[f] <= 64'h0;
                group_block_untranslated_vector[f] <= 64'h0;
                group_receive_vector[f] <= 64'h0;
            end
            function_mcast_enable <= '0;
            function_upstream <= '0;
        end else if (reg_write_in && func_sel) begin
            case (func_off)
                mcast_router_pkg::OFF_BLK_ALL_LOW: begin
                    group_block_all_vector[func_idx][31:0] <= reg_wdata_in;
                end
                mcast_router_pkg::OFF_BLK_ALL_HIGH: begin
                    group_block_all_vector[func_idx][63:32] <= reg_wdata_in;
                end
                mcast_router_pkg::OFF_BLK_UT_LOW: begin
                    group_block_untranslated_vector[func_idx][31:0] <= reg_wdata_in;
                end
                mcast_router_pkg::OFF_BLK_UT_HIGH: begin
                    group_block_untranslated_vector[func_idx][63:32] <= reg_wdata_in;
                end
                mcast_router_pkg::OFF_RCV_LOW: begin
                    group_receive_vector[func_idx][31:0] <= reg_wdata_in;
                end
                mcast_router_pkg::OFF_RCV_HIGH: begin
                    group_receive_vector[func_idx][63:32] <= reg_wdata_in;
                end
                mcast_router_pkg::OFF_FUNC_CTRL: begin
                    function_mcast_enable[func_idx] <= reg_wdata_in[mcast_router_pkg::FCTRL_FUNCTION_MCAST_ENABLE_BIT];
                    function_upstream[func_idx] <= reg_wdata_in[mcast_router_pkg::FCTRL_UPSTREAM_BIT];
                end
                default: begin
                    // Status is write-one-to-clear elsewhere
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register reads

    logic [31:0] next_rdata; // Read mux result

    // Select read data, zero for unmapped
    always_comb begin
        next_rdata = 32'h0;
        if (func_sel) begin
            case (func_off)
                mcast_router_pkg::OFF_BLK_ALL_LOW: next_rdata = group_block_all_vector[func_idx][31:0];
                mcast_router_pkg::OFF_BLK_ALL_HIGH: next_rdata = group_block_all_vector[func_idx][63:32];
                mcast_router_pkg::OFF_BLK_UT_LOW: next_rdata = group_block_untranslated_vector[func_idx][31:0];
                mcast_router_pkg::OFF_BLK_UT_HIGH: next_rdata = group_block_untranslated_vector[func_idx][63:32];
                mcast_router_pkg::OFF_RCV_LOW: next_rdata = group_receive_vector[func_idx][31:0];
                mcast_router_pkg::OFF_RCV_HIGH: next_rdata = group_receive_vector[func_idx][63:32];
                mcast_router_pkg::OFF_FUNC_CTRL: begin
                    next_rdata[mcast_router_pkg::FCTRL_FUNCTION_MCAST_ENABLE_BIT] = function_mcast_enable[func_idx];
                    next_rdata[mcast_router_pkg::FCTRL_UPSTREAM_BIT] = function_upstream[func_idx];
                end
                mcast_router_pkg::OFF_FUNC_STATUS: begin
                    next_rdata[mcast_router_pkg::STS_PRIMARY_BIT] = primary_abort[func_idx];
                    next_rdata[mcast_router_pkg::STS_SECONDARY_BIT] = secondary_abort[func_idx];
                end
                default: next_rdata = 32'h0;
            endcase
        end else begin
            case (reg_addr_in)
                mcast_router_pkg::OFF_CAPABILITY: next_rdata = {26'h0, max_group_count};
                mcast_router_pkg::OFF_CONTROL: begin
                    next_rdata[5:0] = enabled_group_count;
                    next_rdata[mcast_router_pkg::CTRL_ENABLE_BIT] = mcast_global_enable;
                end
                mcast_router_pkg::OFF_BASE_LOW: next_rdata = {mcast_base_low, 6'h00, group_index_position};
                mcast_router_pkg::OFF_BASE_HIGH: next_rdata = mcast_base_high;
                mcast_router_pkg::OFF_HDR_LOG_LOW: next_rdata = hdr_log_addr[31:0];
                mcast_router_pkg::OFF_HDR_LOG_HIGH: next_rdata = hdr_log_addr[63:32];
                mcast_router_pkg::OFF_HDR_LOG_INFO: next_rdata = {24'h0, hdr_log_info};
                default: next_rdata = 32'h0;
            endcase
        end
    end

    // Read data stands the cycle after the strobe only
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            reg_rdata_out <= 32'h0;
        end else if (reg_read_in) begin
            reg_rdata_out <= next_rdata;
        end else begin
            reg_rdata_out <= 32'h0;
        end
    end

endmodule

// ---- verification/mcast_router_monitor.sv ----
`timescale 1ns/1ps
// Ties each routing outcome to its cause
module mcast_router_monitor (
    // Clock, reset, register read
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic reg_read_in,
    input wire logic [31:0] reg_rdata_out,
    // Ingress stream
    input wire logic tlp_valid_in,
    input wire logic [1:0] tlp_ingress_in,
    input wire logic [1:0] tlp_kind_in,
    // Decision outputs
    input wire logic result_valid_out,
    input wire logic route_unicast_out,
    input wire logic is_mcast_out,
    input wire logic [5:0] group_id_out,
    input wire logic [3:0] egress_vector_out,
    input wire logic quiet_discard_out,
    input wire logic acs_violation_out,
    input wire logic common_error_out,
    input wire logic blocked_out,
    input wire logic credit_return_out,
    input wire logic aer_mc_blocked_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    ////////////////////////////////////////////////////////////////
    property p_result; tlp_valid_in |=> result_valid_out; endproperty
    property p_no_result; !tlp_valid_in |=> !result_valid_out; endproperty
    property p_kind; tlp_valid_in && tlp_kind_in[1] |=> route_unicast_out && egress_vector_out == 4'h0; endproperty
    property p_no_self; tlp_valid_in |=> !egress_vector_out[$past(tlp_ingress_in)]; endproperty
    property p_blocked; blocked_out |-> credit_return_out && aer_mc_blocked_out && egress_vector_out == 4'h0;
    endproperty
    property p_quiet; quiet_discard_out |-> is_mcast_out && !aer_mc_blocked_out && egress_vector_out == 4'h0;
    endproperty
    property p_acs; acs_violation_out |-> is_mcast_out && !blocked_out && egress_vector_out == 4'h0; endproperty
    property p_uni; route_unicast_out |-> !is_mcast_out && group_id_out == 6'h00; endproperty
    property p_common; common_error_out |-> is_mcast_out && !blocked_out && egress_vector_out == 4'h0; endproperty
    property p_rdata; !reg_read_in |=> reg_rdata_out == 32'h0; endproperty
    a_result: assert property (p_result) else $error("no result after request");
    a_no_result: assert property (p_no_result) else $error("result without request");
    a_kind: assert property (p_kind) else $error("other kind not unicast");
    a_no_self: assert property (p_no_self) else $error("ingress accepted own TLP");
    a_blocked: assert property (p_blocked) else $error("blocked handling incomplete");
    a_quiet: assert property (p_quiet) else $error("quiet discard reported");
    a_acs: assert property (p_acs) else $error("source check failure forwarded");
    a_uni: assert property (p_uni) else $error("unicast with group");
    a_common: assert property (p_common) else $error("errored multicast forwarded");
    a_rdata: assert property (p_rdata) else $error("read data without read");
    c_blocked: cover property (blocked_out);
    c_quiet: cover property (quiet_discard_out);
    c_fwd: cover property (egress_vector_out != 4'h0);
endmodule
bind multicast_tlp_router mcast_router_monitor u_mcast_router_monitor (.*);

// ---- verification/pcie_partner_model.sv ----
`timescale 1ns/1ps
// Link partner: offers one posted TLP per call
module pcie_partner_model (
    // Clock
    input wire logic core_clk_in,
    // Stream toward the router
    output logic tlp_valid_out = 1'b0,
    output logic [1:0] tlp_ingress_out = 2'h0,
    output logic [1:0] tlp_kind_out = 2'h0,
    output logic [63:0] tlp_addr_out = 64'h0,
    output logic [1:0] tlp_at_out = 2'h0,
    output logic tlp_acs_fail_out = 1'b0,
    output logic tlp_error_out = 1'b0
);
    // Hold fields with valid, then scramble address and AT
    task automatic send(input logic [1:0] ing, kind, input logic [63:0] a, input logic [1:0] at,
                        input logic acs, err);
        tlp_valid_out <= 1'b1;
        tlp_ingress_out <= ing;
        tlp_kind_out <= kind;
        tlp_addr_out <= a;
        tlp_at_out <= at;
        tlp_acs_fail_out <= acs;
        tlp_error_out <= err;
        @(posedge core_clk_in);
        tlp_valid_out <= 1'b0;
        tlp_addr_out <= ~a;
        tlp_at_out <= ~at;
    endtask
endmodule

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
// Self-checking bench for the multicast router
module testbench;
    // Clock, reset, register port
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] reg_addr_in = 8'h00;
    logic [31:0] reg_wdata_in = 32'h0;
    logic reg_write_in = 1'b0;
    logic reg_read_in = 1'b0;
    logic [31:0] reg_rdata_out;
    // Stream and decisions
    logic tlp_valid_in, tlp_acs_fail_in, tlp_error_in;
    logic [1:0] tlp_ingress_in, tlp_kind_in, tlp_at_in;
    logic [63:0] tlp_addr_in;
    logic result_valid_out, route_unicast_out, is_mcast_out, quiet_discard_out, acs_violation_out;
    logic common_error_out, blocked_out, credit_return_out, aer_mc_blocked_out;
    logic [5:0] group_id_out;
    logic [3:0] egress_vector_out;
    // Counters and per-function setup
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;
    logic fen [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
    logic [31:0] rcv [4] = '{32'h7, 32'h5, 32'h4, 32'h7};
    localparam logic [63:0] BASE = 64'h0000_0001_0010_0000;
    multicast_tlp_router u_multicast_tlp_router (.*);
    pcie_partner_model u_pcie_partner_model (.core_clk_in(core_clk_in), .tlp_valid_out(tlp_valid_in),
        .tlp_ingress_out(tlp_ingress_in), .tlp_kind_out(tlp_kind_in), .tlp_addr_out(tlp_addr_in),
        .tlp_at_out(tlp_at_in), .tlp_acs_fail_out(tlp_acs_fail_in), .tlp_error_out(tlp_error_in));
    always #25 core_clk_in = ~core_clk_in;
    // Hang guard
    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            tally_and_finish;
        end
    end
    ////////////////////////////////////////////////////////////////
    function automatic logic [63:0] mc(input int g);
        mc = BASE + (64'(g) << 12);
    endfunction
    function automatic logic [3:0] eg_of(input int ing, input int g);
        for (int f = 0; f < 4; f++) eg_of[f] = f != ing && fen[f] && rcv[f][g];
    endfunction
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_write_in <= 1'b1;
        @(posedge core_clk_in);
        reg_write_in <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        reg_addr_in <= a;
        reg_read_in <= 1'b1;
        @(posedge core_clk_in);
        reg_read_in <= 1'b0;
        #1;
        chk(reg_rdata_out, exp);
    endtask
    // Flags are {quiet, blocked, credit, aer, acs, common}
    task automatic tx(input logic [1:0] ing, kind, input logic [63:0] a, input logic [1:0] at,
                      input logic acs, err, m, input logic [5:0] g, input logic [3:0] eg, input logic [5:0] fl);
        u_pcie_partner_model.send(ing, kind, a, at, acs, err);
        #1;
        chk({result_valid_out, route_unicast_out, is_mcast_out, group_id_out, egress_vector_out, quiet_discard_out,
             blocked_out, credit_return_out, aer_mc_blocked_out, acs_violation_out, common_error_out},
            {1'b1, !m, m, g, eg, fl});
    endtask
    task automatic uni(input logic [1:0] kind, input logic [63:0] a);
        tx(2'h0, kind, a, 2'h1, 1'b0, 1'b0, 1'b0, 6'h00, 4'h0, 6'h00);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_reset_disabled;
        rd(8'h00, 32'h1F);
        rd(8'h1C, 32'h0);
        uni(2'h0, mc(0));
        $display("reset and disabled test done");
    endtask
    task automatic t_config;
        wr(8'h00, 32'h3F);
        rd(8'h00, 32'h3F);
        wr(8'h04, 32'h0000_8002);
        wr(8'h08, 32'h0010_000C);
        wr(8'h0C, 32'h1);
        for (int f = 0; f < 4; f++) begin
            wr(8'(8'h98 + f * 32), {30'h0, f == 0, fen[f]});
            wr(8'(8'h90 + f * 32), rcv[f]);
        end
        wr(8'h94, 32'hA5A5_0000);
        rd(8'h94, 32'hA5A5_0000);
        $display("config test done");
    endtask
    task automatic t_route;
        for (int i = 0; i < 2; i++) begin
            for (int g = 0; g < 3; g++) begin
                for (int k = 0; k < 2; k++) begin
                    tx(2'(i), 2'(k), mc(g), 2'h1, 1'b0, 1'b0, 1'b1, 6'(g), eg_of(i, g), {eg_of(i, g) == 0, 5'h0});
                end
            end
        end
        tx(2'h0, 2'h0, mc(2) + 64'h7FC, 2'h1, 1'b0, 1'b0, 1'b1, 6'h02, 4'h6, 6'h00);
        uni(2'h2, mc(0));
        uni(2'h0, mc(3));
        uni(2'h0, mc(0) | 64'h4000);
        uni(2'h0, 64'h0000_0002_0010_0000);
        $display("routing test done");
    endtask
    task automatic t_block;
        wr(8'hC0, 32'h1);
        tx(2'h2, 2'h0, mc(0), 2'h1, 1'b0, 1'b0, 1'b1, 6'h00, 4'h0, 6'h1C);
        rd(8'hDC, 32'h2);
        rd(8'h10, 32'h0010_0000);
        rd(8'h18, 32'h6);
        wr(8'h88, 32'h4);
        tx(2'h0, 2'h0, mc(2), 2'h1, 1'b0, 1'b0, 1'b1, 6'h02, 4'h6, 6'h00);
        tx(2'h0, 2'h0, mc(2), 2'h0, 1'b0, 1'b0, 1'b1, 6'h02, 4'h0, 6'h1C);
        rd(8'h9C, 32'h1);
        wr(8'h9C, 32'h1);
        rd(8'h9C, 32'h0);
        $display("block test done");
    endtask
    task automatic t_errors;
        tx(2'h1, 2'h0, mc(0), 2'h1, 1'b1, 1'b0, 1'b1, 6'h00, 4'h0, 6'h02);
        tx(2'h1, 2'h1, mc(0), 2'h1, 1'b0, 1'b1, 1'b1, 6'h00, 4'h0, 6'h01);
        $display("error test done");
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (4) @(posedge core_clk_in);
        rst_in <= 1'b0;
        t_reset_disabled;
        t_config;
        t_route;
        t_block;
        t_errors;
        tally_and_finish;
    end
endmodule
